// >>> verilog/wwdt_pkg.sv
package wwdt_pkg;
  // Nominal low-power RC frequency and the two prescaler periods it yields
  localparam int RC_OSC_HZ = 32000;
  localparam int PRE_SHORT_MS = 1;
  localparam int PRE_LONG_MS = 4;
  localparam int PRE_DIV_SHORT = RC_OSC_HZ * PRE_SHORT_MS / 1000;
  localparam int PRE_DIV_LONG = RC_OSC_HZ * PRE_LONG_MS / 1000;
  // Counter and field widths
  localparam int PRE_W = 7;
  localparam int POST_W = 15;
  localparam int SEL_W = 4;
  localparam int SPAN_W = 26;
  localparam int CFG_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Configuration word layout
  localparam int CFG_POST_LSB = 0;
  localparam int CFG_PRE_BIT = 4;
  localparam int CFG_WINDOW_DIS_BIT = 6;
  localparam int CFG_HWEN_BIT = 7;
  // Reset control register layout
  localparam int RC_IDLE_BIT = 2;
  localparam int RC_SLEEP_BIT = 3;
  localparam int RC_TIMEOUT_BIT = 4;
  localparam int RC_SWEN_BIT = 5;
  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ELAPSED = 4'h1;
  // Clear window: final quarter of the period
  localparam logic [SPAN_W-1:0] WIN_NUM = 26'h3;
  localparam logic [SPAN_W-1:0] WIN_DEN = 26'h4;
  // Execution modes of the core as seen by the watchdog
  typedef enum logic [2:0] {
    WWDT_RUN = 3'b001,
    WWDT_SLEEP = 3'b010,
    WWDT_IDLE = 3'b100
  } wwdt_mode_type;
endpackage : wwdt_pkg

// >>> verilog/wwdt_prescaler.sv
module wwdt_prescaler #(
  parameter int PRE_W = wwdt_pkg::PRE_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clear,
  input wire logic rc_tick,
  input wire logic prescale_select,
  output logic pre_tick,
  output logic [PRE_W-1:0] pre_count
);
  import wwdt_pkg::*;

  // Refuse a counter too narrow for the long division
  if (PRE_W < $clog2(PRE_DIV_LONG)) begin : g_bad_width
    $error("wwdt_prescaler: PRE_W too small");
  end

  logic [PRE_W-1:0] pre_last; // Terminal count for the selected ratio

  // Select one means divide by the long ratio
  always_comb begin
    if (prescale_select) begin
      pre_last = PRE_W'(PRE_DIV_LONG - 1);
    end else begin
      pre_last = PRE_W'(PRE_DIV_SHORT - 1);
    end
  end

  // Output pulse on the low-power edge that closes a prescaler period
  assign pre_tick = rc_tick && (pre_count >= pre_last);

  // Count low-power clock edges; a clear always wins over counting
  always_ff @(posedge clk_sys) begin
    if (reset || clear) begin
      pre_count <= '0;
    end else if (pre_tick) begin
      pre_count <= '0;
    end else if (rc_tick) begin
      pre_count <= pre_count + PRE_W'(1);
    end
  end
endmodule : wwdt_prescaler

// >>> verilog/wwdt_postscaler.sv
module wwdt_postscaler #(
  parameter int POST_W = wwdt_pkg::POST_W,
  parameter int SEL_W = wwdt_pkg::SEL_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clear,
  input wire logic pre_tick,
  input wire logic [SEL_W-1:0] postscale_select,
  output logic expire,
  output logic [POST_W-1:0] post_count
);
  import wwdt_pkg::*;

  // The largest ratio must fit the counter
  if (POST_W < (1 << SEL_W) - 1) begin : g_bad_width
    $error("wwdt_postscaler: POST_W too small");
  end

  logic [POST_W-1:0] post_last; // Ratio two to the N, minus one

  // Field value N selects a ratio of two to the N
  assign post_last = POST_W'((32'h1 << postscale_select) - 32'h1);

  // Time-out pulse on the prescaler tick that ends the period
  assign expire = pre_tick && (post_count >= post_last);

  // Count prescaler periods; a clear always wins over counting
  always_ff @(posedge clk_sys) begin
    if (reset || clear) begin
      post_count <= '0;
    end else if (expire) begin
      post_count <= '0;
    end else if (pre_tick) begin
      post_count <= post_count + POST_W'(1);
    end
  end
endmodule : wwdt_postscaler

// >>> verilog/wwdt_top.sv
// Overview of operation
// - Low-power RC clocks watchdog; enable runs it
// - Prescaler divides by 32 or 128
// - Nominal prescaler period 1 ms or 4 ms
// - Four-bit postscaler gives sixteen ratios
// - Device reset clears all watchdog counters
// - Completed clock switch clears all counters
// - Power-save entry and exit clear counters
// - Clear instruction resets counter and scalers
// - Watchdog keeps counting in sleep, idle
// - Time-out in power save wakes, no reset
// - Time-out flag sticks until software clears
// - Hardware enable forces watchdog always on
// - Otherwise software enable bit five gates it
// - Device reset clears software enable bit
// - Early clear in window mode resets device
// - Select one is 1:128, zero 1:32
// - Window disable one is non-window mode
module wwdt_top #(
  parameter int PRE_W = wwdt_pkg::PRE_W,
  parameter int POST_W = wwdt_pkg::POST_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic low_power_rc_osc,
  input wire logic [wwdt_pkg::CFG_W-1:0] watchdog_config_word,
  input wire logic watchdog_clear_instr,
  input wire logic power_save_instr,
  input wire logic power_save_idle,
  input wire logic osc_switch_done,
  input wire logic power_save_exit,
  input wire logic [wwdt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wwdt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [wwdt_pkg::DATA_W-1:0] reg_rdata,
  output logic rc_osc_enable,
  output logic wdt_reset_req,
  output logic wdt_wake,
  output logic wdt_running
);
  import wwdt_pkg::*;

  // Span arithmetic needs room for the longest period times the window numerator
  if (PRE_W + POST_W + 2 > SPAN_W) begin : g_bad_span
    $error("wwdt_top: counters too wide for window arithmetic");
  end

  // Low-power clock period count, in RC edges, for a given setting
  function automatic logic [SPAN_W-1:0] span_ticks(
    input logic pre_sel,
    input logic [SEL_W-1:0] post_sel
  );
    logic [SPAN_W-1:0] div;
    div = pre_sel ? SPAN_W'(PRE_DIV_LONG) : SPAN_W'(PRE_DIV_SHORT);
    return div << post_sel;
  endfunction : span_ticks

  // Configuration fields
  logic [SEL_W-1:0] postscale_select; // Postscaler ratio code
  logic prescale_select; // One selects the long prescaler
  logic window_disable; // One selects non-window mode
  logic hw_wdt_enable; // Watchdog permanently on

  assign postscale_select = watchdog_config_word[CFG_POST_LSB +: SEL_W];
  assign prescale_select = watchdog_config_word[CFG_PRE_BIT];
  assign window_disable = watchdog_config_word[CFG_WINDOW_DIS_BIT];
  assign hw_wdt_enable = watchdog_config_word[CFG_HWEN_BIT];

  // Software-visible state
  logic soft_wdt_enable; // Software enable
  logic timeout_flag; // Sticky time-out flag
  logic sleep_flag; // Entered sleep
  logic idle_flag; // Entered idle
  wwdt_mode_type mode; // Core execution mode
  wwdt_mode_type next_mode;

  // Low-power clock synchroniser and edge detect
  logic rc_meta; // First stage, read only by the second
  logic rc_sync; // Second stage
  logic rc_prev; // Delayed copy for the edge
  logic rc_tick; // One pulse per RC rising edge

  // Counter chain
  logic pre_tick;
  logic expire;
  logic [PRE_W-1:0] pre_count;
  logic [POST_W-1:0] post_count;

  // Decoded events
  logic wdt_en; // Watchdog active
  logic run_mode; // Normal execution
  logic clr_run; // Clear instruction during normal execution
  logic window_open; // Inside final quarter
  logic early_clear; // Clear before the window opens
  logic cnt_clear; // Any cause that restarts the counters
  logic exit_ps; // Leaving sleep or idle
  logic rc_write; // Write to the reset control register
  logic [SPAN_W-1:0] elapsed; // Elapsed RC edges in this period

  assign wdt_en = hw_wdt_enable || soft_wdt_enable;
  assign run_mode = (mode == WWDT_RUN);
  assign clr_run = watchdog_clear_instr && run_mode;
  assign rc_write = reg_write && (reg_addr == ADDR_RESET_CTRL);
  assign exit_ps = !run_mode && (power_save_exit || (wdt_en && expire));

  // Position within the period, in RC edges
  assign elapsed = SPAN_W'(post_count) * span_ticks(prescale_select, SEL_W'(0))
    + SPAN_W'(pre_count);

  // Open once elapsed time reaches three quarters of the period
  assign window_open = (elapsed * WIN_DEN)
    >= (span_ticks(prescale_select, postscale_select) * WIN_NUM);

  // Only window mode punishes an early clear
  assign early_clear = clr_run && wdt_en && !window_disable && !window_open;

  // Every restart cause; a disabled watchdog is held at zero as well
  always_comb begin
    cnt_clear = wdt_reset_req
      || osc_switch_done
      || (run_mode && power_save_instr) || exit_ps
      || clr_run
      || !wdt_en;
  end

  // Two flip-flops before the slow clock is looked at
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      rc_meta <= low_power_rc_osc;
      rc_sync <= rc_meta;
      rc_prev <= rc_sync;
    end
  end

  // Only the RC oscillator advances the watchdog
  assign rc_tick = rc_sync && !rc_prev;

  // Prescaler, divide by 32 or 128
  wwdt_prescaler #(
    .PRE_W(PRE_W)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(cnt_clear),
    .rc_tick(rc_tick),
    .prescale_select(prescale_select),
    .pre_tick(pre_tick),
    .pre_count(pre_count)
  );

  // Postscaler, ratio two to the N
  wwdt_postscaler #(
    .POST_W(POST_W),
    .SEL_W(SEL_W)
  ) u_postscaler (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(cnt_clear),
    .pre_tick(pre_tick),
    .postscale_select(postscale_select),
    .expire(expire),
    .post_count(post_count)
  );

  // Mode tracking; counting continues in every mode while enabled
  always_comb begin
    next_mode = mode;
    case (mode)
      WWDT_RUN: begin
        if (power_save_instr) begin
          next_mode = power_save_idle ? WWDT_IDLE : WWDT_SLEEP;
        end
      end
      WWDT_SLEEP, WWDT_IDLE: begin
        // Time-out resumes execution instead of resetting
        if (exit_ps) begin
          next_mode = WWDT_RUN;
        end
      end
      default: begin
        next_mode = WWDT_RUN;
      end
    endcase
  end

  // Mode register; a watchdog reset restarts the core in run mode
  always_ff @(posedge clk_sys) begin
    if (reset || wdt_reset_req) begin
      mode <= WWDT_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Reset request on run-mode time-out or early clear
  always_ff @(posedge clk_sys) begin
    if (reset || wdt_reset_req) begin
      wdt_reset_req <= 1'b0;
    end else begin
      wdt_reset_req <= (run_mode && wdt_en && expire) || early_clear;
    end
  end

  // Wake pulse when a time-out ends sleep or idle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wdt_wake <= 1'b0;
    end else begin
      wdt_wake <= !run_mode && wdt_en && expire;
    end
  end

  // Oscillator request and running indication follow the enable
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rc_osc_enable <= 1'b0;
      wdt_running <= 1'b0;
    end else begin
      rc_osc_enable <= wdt_en;
      wdt_running <= wdt_en;
    end
  end

  // Software enable; any device reset, including our own, clears it
  always_ff @(posedge clk_sys) begin
    if (reset || wdt_reset_req) begin
      soft_wdt_enable <= 1'b0;
    end else if (rc_write) begin
      soft_wdt_enable <= reg_wdata[RC_SWEN_BIT];
    end
  end

  // Sticky time-out flag: set wins over a software write; survives our own reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timeout_flag <= 1'b0;
    end else if ((wdt_en && expire) || early_clear) begin
      timeout_flag <= 1'b1;
    end else if (rc_write) begin
      timeout_flag <= reg_wdata[RC_TIMEOUT_BIT];
    end
  end

  // Power-save status; hardware never clears these on wake
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sleep_flag <= 1'b0;
      idle_flag <= 1'b0;
    end else begin
      if (run_mode && power_save_instr && !power_save_idle) begin
        sleep_flag <= 1'b1;
      end else if (rc_write) begin
        sleep_flag <= reg_wdata[RC_SLEEP_BIT];
      end
      if (run_mode && power_save_instr && power_save_idle) begin
        idle_flag <= 1'b1;
      end else if (rc_write) begin
        idle_flag <= reg_wdata[RC_IDLE_BIT];
      end
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_RESET_CTRL: begin
          reg_rdata <= '0;
          reg_rdata[RC_IDLE_BIT] <= idle_flag;
          reg_rdata[RC_SLEEP_BIT] <= sleep_flag;
          reg_rdata[RC_TIMEOUT_BIT] <= timeout_flag;
          reg_rdata[RC_SWEN_BIT] <= soft_wdt_enable;
        end
        ADDR_ELAPSED: begin
          reg_rdata <= DATA_W'(post_count);
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_run_timeout: assert property (run_mode && wdt_en && expire |=> wdt_reset_req)
    else $error("run-mode time-out gave no reset request");
  a_timeout_flag: assert property (wdt_reset_req || wdt_wake |-> timeout_flag)
    else $error("time-out flag not set with reset or wake");
  a_flag_sticky: assert property (timeout_flag && !rc_write |=> timeout_flag)
    else $error("time-out flag cleared without a write");
  a_wake_resume: assert property (!run_mode && wdt_en && expire
    |=> wdt_wake && !wdt_reset_req && run_mode)
    else $error("power-save time-out did not wake cleanly");
  a_early_reset: assert property (early_clear |=> wdt_reset_req ##1 !soft_wdt_enable)
    else $error("early clear did not reset");
  a_nowin_clear: assert property (clr_run && window_disable && !expire
    |=> !wdt_reset_req)
    else $error("clear refused in non-window mode");
  a_hw_enable: assert property (hw_wdt_enable |=> rc_osc_enable)
    else $error("hardware enable did not run the oscillator");
  a_counter_clear: assert property (cnt_clear |=> pre_count == '0 && post_count == '0)
    else $error("counters not cleared");
  a_sleep_count: assert property (!run_mode && wdt_en && rc_tick && !pre_tick && !cnt_clear
    |=> pre_count == $past(pre_count) + PRE_W'(1))
    else $error("prescaler stalled in power save");
  a_soft_reset: assert property (wdt_reset_req |=> !soft_wdt_enable && run_mode)
    else $error("watchdog reset left software enable set");

  c_run_timeout: cover property (run_mode && wdt_en && expire);
  c_wake: cover property (wdt_wake);
  c_early: cover property (early_clear);
  c_good_clear: cover property (clr_run && wdt_en && window_open && !window_disable);
endmodule : wwdt_top

// >>> tb/wwdt_tb_top.sv
// Compare two values; a mismatch is reported and counted at once
`define WWDT_CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module wwdt_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wwdt_pkg::*;

  localparam int TICK = 4; // Clock cycles per RC rising edge
  localparam int TOL = 6; // Slack for synchroniser latency and tick phase
  localparam int LIMIT = 40000; // Run ceiling, well above the planned sequence
  localparam logic [DATA_W-1:0] IDLE_F = 16'h1 << RC_IDLE_BIT;
  localparam logic [DATA_W-1:0] SLEEP_F = 16'h1 << RC_SLEEP_BIT;
  localparam logic [DATA_W-1:0] TO_F = 16'h1 << RC_TIMEOUT_BIT;
  localparam logic [DATA_W-1:0] SWEN_F = 16'h1 << RC_SWEN_BIT;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic low_power_rc_osc = 1'b0;
  logic [CFG_W-1:0] watchdog_config_word;
  logic watchdog_clear_instr = 1'b0;
  logic power_save_instr = 1'b0;
  logic power_save_idle = 1'b0;
  logic osc_switch_done = 1'b0;
  logic power_save_exit = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic rc_osc_enable;
  logic wdt_reset_req;
  logic wdt_wake;
  logic wdt_running;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  int rc_div = 0;
  int pre_t [4] = '{0, 1, 0, 1}; // Prescale choices swept
  int post_t [4] = '{0, 0, 3, 1}; // Postscale choices swept, kept short for run time

  // Build a configuration word from its fields
  function automatic logic [CFG_W-1:0] mkcfg(input logic hw, input logic wd, input logic pre,
                                              input logic [SEL_W-1:0] n);
    mkcfg = '0;
    mkcfg[CFG_HWEN_BIT] = hw;
    mkcfg[CFG_WINDOW_DIS_BIT] = wd;
    mkcfg[CFG_PRE_BIT] = pre;
    mkcfg[CFG_POST_LSB +: SEL_W] = n;
  endfunction : mkcfg

  initial watchdog_config_word = mkcfg(1'b0, 1'b1, 1'b0, 4'h0);

  wwdt_top i_dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .low_power_rc_osc(low_power_rc_osc),
    .watchdog_config_word(watchdog_config_word),
    .watchdog_clear_instr(watchdog_clear_instr),
    .power_save_instr(power_save_instr),
    .power_save_idle(power_save_idle),
    .osc_switch_done(osc_switch_done),
    .power_save_exit(power_save_exit),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .rc_osc_enable(rc_osc_enable),
    .wdt_reset_req(wdt_reset_req),
    .wdt_wake(wdt_wake),
    .wdt_running(wdt_running)
  );

  // System clock, 100 MHz
  always #5 clk_sys = ~clk_sys;

  // Fast stand-in for the RC oscillator: one rising edge every four cycles
  always @(posedge clk_sys) begin
    rc_div <= rc_div + 1;
    if (rc_div % 2 == 1) begin
      low_power_rc_osc <= ~low_power_rc_osc;
    end
  end

  // Hang guard: a run this long means an event never came
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      results();
    end
  end

  // Print counts and verdict, then stop
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // One-cycle register write
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : reg_wr

  // One-cycle register read; data are taken in the following cycle only
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    `WWDT_CHK(reg_rdata, exp)
  endtask : rd_chk

  // One-cycle core event: 0 clear, 1 clock switch, 2 power save, 3 wake-up exit
  task automatic pulse(input int k);
    @(posedge clk_sys);
    case (k)
      0: watchdog_clear_instr <= 1'b1;
      1: osc_switch_done <= 1'b1;
      2: power_save_instr <= 1'b1;
      default: power_save_exit <= 1'b1;
    endcase
    @(posedge clk_sys);
    watchdog_clear_instr <= 1'b0;
    osc_switch_done <= 1'b0;
    power_save_instr <= 1'b0;
    power_save_exit <= 1'b0;
  endtask : pulse

  // Count cycles until a reset request or wake pulse, bounded by max
  task automatic wait_evt(input int max, output int n, output logic w);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wdt_reset_req !== 1'b1 && wdt_wake !== 1'b1 && n < max);
    w = wdt_wake;
  endtask : wait_evt

  // Expect the next event after exp cycles, of the given kind
  task automatic period_chk(input int exp, input logic exp_wake);
    int n;
    logic w;
    wait_evt(exp + 4 * TOL, n, w);
    `WWDT_CHK(n >= exp - TOL && n <= exp + TOL, 1'b1)
    `WWDT_CHK(w, exp_wake)
  endtask : period_chk

  initial begin
    int n;
    logic w;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(ADDR_RESET_CTRL, '0);
    rd_chk(4'h7, '0);
    `WWDT_CHK(wdt_running, 1'b0)
    // Disabled: no event may come at all
    wait_evt(300, n, w);
    `WWDT_CHK(n, 300)
    reg_wr(ADDR_RESET_CTRL, SWEN_F);
    repeat (2) @(posedge clk_sys);
    `WWDT_CHK(rc_osc_enable, 1'b1)
    rd_chk(ADDR_RESET_CTRL, SWEN_F);
    pulse(0);
    period_chk(32 * TICK, 1'b0);
    // The time-out reset drops the soft enable but keeps the flag
    rd_chk(ADDR_RESET_CTRL, TO_F);
    `WWDT_CHK(wdt_running, 1'b0)
    repeat (200) @(posedge clk_sys);
    rd_chk(ADDR_RESET_CTRL, TO_F);
    reg_wr(ADDR_RESET_CTRL, '0);
    rd_chk(ADDR_RESET_CTRL, '0);
    // Hardware enable with a sweep of prescale and postscale settings
    for (int i = 0; i < 4; i++) begin
      watchdog_config_word <= mkcfg(1'b1, 1'b1, pre_t[i] != 0, SEL_W'(post_t[i]));
      pulse(0);
      period_chk((pre_t[i] ? 128 : 32) * TICK << post_t[i], 1'b0);
    end
    reg_wr(ADDR_RESET_CTRL, '0);
    repeat (2) @(posedge clk_sys);
    `WWDT_CHK(wdt_running, 1'b1)
    // Ratio 1:4: about 75 RC edges after a clear the postscaler holds two
    watchdog_config_word <= mkcfg(1'b1, 1'b1, 1'b0, 4'h2);
    pulse(0);
    repeat (300) @(posedge clk_sys);
    rd_chk(ADDR_ELAPSED, 16'h2);
    // Restart in mid-period by clear, clock switch and power-save entry
    watchdog_config_word <= mkcfg(1'b1, 1'b1, 1'b0, 4'h0);
    for (int k = 0; k < 3; k++) begin
      pulse(0);
      repeat (80) @(posedge clk_sys);
      pulse(k);
      period_chk(32 * TICK, k == 2);
    end
    rd_chk(ADDR_RESET_CTRL, SLEEP_F | TO_F);
    reg_wr(ADDR_RESET_CTRL, '0);
    rd_chk(ADDR_RESET_CTRL, '0);
    // Idle entry, then an exit for another reason restarts the count
    power_save_idle <= 1'b1;
    pulse(0);
    pulse(2);
    rd_chk(ADDR_RESET_CTRL, IDLE_F);
    repeat (80) @(posedge clk_sys);
    pulse(3);
    period_chk(32 * TICK, 1'b0);
    reg_wr(ADDR_RESET_CTRL, '0);
    // Window mode: start counting from a time-out reset
    watchdog_config_word <= mkcfg(1'b1, 1'b0, 1'b0, 4'h0);
    wait_evt(200, n, w);
    repeat (38) @(posedge clk_sys);
    pulse(0);
    wait_evt(4, n, w);
    `WWDT_CHK(n <= 2 && w === 1'b0, 1'b1)
    rd_chk(ADDR_RESET_CTRL, TO_F);
    // Clear issued inside the last quarter, as software should
    repeat (100) @(posedge clk_sys);
    pulse(0);
    period_chk(32 * TICK, 1'b0);
    // Device reset in mid-run clears flags and enable
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(ADDR_RESET_CTRL, '0);
    results();
  end
endmodule : wwdt_tb_top
